// ===== conmt_pkg.sv
// Package: constants and types for the network-management state block
package conmt_pkg;
  typedef enum logic [1:0] {
    NmtInit,
    NmtPreOp,
    NmtOper,
    NmtStopped
  } conmt_state_t;

  typedef enum logic [2:0] {
    AreaNone,
    AreaDataType,
    AreaReserved,
    AreaComm,
    AreaMfr,
    AreaDevice
  } conmt_area_t;

  localparam logic [10:0] NMT_COB_ID     = 11'h000;
  localparam logic [10:0] SDO_RX_BASE    = 11'h600;
  localparam logic [10:0] SDO_TX_BASE    = 11'h580;
  localparam logic [7:0]  NMT_BROADCAST  = 8'h00;
  localparam logic [3:0]  NMT_DLC        = 4'h2;
  localparam logic [7:0]  CMD_START      = 8'h01;
  localparam logic [7:0]  CMD_STOP       = 8'h02;
  localparam logic [7:0]  CMD_PREOP      = 8'h80;
  localparam logic [7:0]  CMD_RST_NODE   = 8'h81;
  localparam logic [7:0]  CMD_RST_COMM   = 8'h82;

  localparam logic [15:0] IDX_TYPES_LO   = 16'h0001;
  localparam logic [15:0] IDX_RES1_LO    = 16'h00a0;
  localparam logic [15:0] IDX_COMM_LO    = 16'h1000;
  localparam logic [15:0] IDX_MFR_LO     = 16'h2000;
  localparam logic [15:0] IDX_DEV_LO     = 16'h6000;
  localparam logic [15:0] IDX_RES2_LO    = 16'ha000;

  // Bit-rate codes; 10 kbit/s is absent on purpose
  localparam logic [2:0]  RATE_1M        = 3'h0;
  localparam logic [2:0]  RATE_800K      = 3'h1;
  localparam logic [2:0]  RATE_500K      = 3'h2;
  localparam logic [2:0]  RATE_250K      = 3'h3;
  localparam logic [2:0]  RATE_125K      = 3'h4;
  localparam logic [2:0]  RATE_50K       = 3'h5;
  localparam logic [2:0]  RATE_20K       = 3'h6;
  localparam logic [2:0]  RATE_DEFAULT   = RATE_250K;
  localparam logic [6:0]  NODE_DEFAULT   = 7'h01;

  localparam int          CLK_HZ         = 50000000;
  localparam int          BOOT_MAX_S     = 5;
  localparam int          BOOT_WAIT_MS   = 2000;
  localparam int          BOOT_CYCLES    = CLK_HZ / 1000 * BOOT_WAIT_MS;
  localparam int          NUM_RPDO       = 2;
  localparam int          NUM_TPDO       = 2;
endpackage

// ===== conmt_od_decode.sv
// Dictionary index area decoder
`timescale 1ns/1ps
`default_nettype none
module conmt_od_decode (
  input  wire logic [15:0]         odIndex,
  input  wire logic [7:0]          odSubIndex,
  output conmt_pkg::conmt_area_t   odArea,
  output logic [7:0]               odSub
);
  always_comb begin
    odSub = odSubIndex; // RL2
    if (odIndex >= conmt_pkg::IDX_RES2_LO) begin // RL3
      odArea = conmt_pkg::AreaReserved;
    end else if (odIndex >= conmt_pkg::IDX_DEV_LO) begin
      odArea = conmt_pkg::AreaDevice;
    end else if (odIndex >= conmt_pkg::IDX_MFR_LO) begin
      odArea = conmt_pkg::AreaMfr;
    end else if (odIndex >= conmt_pkg::IDX_COMM_LO) begin
      odArea = conmt_pkg::AreaComm;
    end else if (odIndex >= conmt_pkg::IDX_RES1_LO) begin
      odArea = conmt_pkg::AreaReserved;
    end else if (odIndex >= conmt_pkg::IDX_TYPES_LO) begin
      odArea = conmt_pkg::AreaDataType;
    end else begin
      odArea = conmt_pkg::AreaNone;
    end
  end
endmodule
`default_nettype wire

// ===== conmt_state_ctrl.sv
// Network-management state machine with service gating
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1 - Dictionary entries use 16-bit index
// RL2 - Subindex selects element, 8 bits wide
// RL3 - Classify index into profile areas
// RL4 - Boot-up sent within five seconds
// RL5 - Pre-operational sends only configured heartbeat
// RL6 - Operational sends enabled PDOs as configured
// RL7 - Services gated by current network state
// RL8 - NMT frame id zero, command, node
// RL9 - 01 operational, 02 stopped, 80 pre-op
// RL10 - 81 resets all, 82 resets comms
// RL11 - State changes only on external events; init goes to pre-op on its own when the boot delay ends
// RL12 - Two RPDO, two TPDO, one SDO
// RL13 - Node id and rate written via SDO
// RL14 - Written parameters kept non-volatile
// RL15 - SDO rx 600+node, tx 580+node
// RL16 - Rates 1M down to 20k only
// RL17 - Ignore foreign address or unknown command
// RL18 - After reset: init, boot-up, pre-op
module conmt_state_ctrl #(
  parameter int BOOT_CYCLES = conmt_pkg::BOOT_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 rxValid,
  input  wire logic [10:0]          rxCobId,
  input  wire logic [3:0]           rxDlc,
  input  wire logic [7:0]           rxByte0,
  input  wire logic [7:0]           rxByte1,
  input  wire logic                 cfgWrite,
  input  wire logic [6:0]           cfgNodeId,
  input  wire logic [2:0]           cfgBitRate,
  input  wire logic                 nvLoaded,
  input  wire logic [6:0]           nvNodeId,
  input  wire logic [2:0]           nvBitRate,
  input  wire logic                 hbEnable,
  input  wire logic                 hbTick,
  input  wire logic [1:0]           tpdoEnable,
  input  wire logic [1:0]           tpdoTrigger,
  input  wire logic                 syncRx,
  input  wire logic [15:0]          odIndex,
  input  wire logic [7:0]           odSubIndex,
  output logic [1:0]                nmtState,
  output logic                      bootTx,
  output logic                      hbTx,
  output logic [1:0]                tpdoTx,
  output logic                      rpdoAccept,
  output logic                      sdoAccept,
  output logic                      syncAccept,
  output logic                      sdoRespTx,
  output logic [10:0]               sdoRxId,
  output logic [10:0]               sdoTxId,
  output logic [6:0]                nodeId,
  output logic [2:0]                bitRate,
  output logic                      nvStore,
  output logic                      appReset,
  output logic [2:0]                odArea,
  output logic [7:0]                odSub
);
  // ***********************************************
  // Frame decode
  // ***********************************************
  conmt_pkg::conmt_state_t stateFf;
  conmt_pkg::conmt_state_t nxtState;
  conmt_pkg::conmt_area_t  areaComb;
  logic [7:0]  subComb;
  logic [31:0] bootCntFf;
  logic        bootDoneFf;
  logic [6:0]  nodeFf;
  logic [2:0]  rateFf;
  logic        nmtHit;
  logic        sdoHit;
  logic        cmdKnown;

  function automatic logic rateOk(input logic [2:0] r);
    rateOk = (r <= conmt_pkg::RATE_20K); // RL16
  endfunction

  always_comb begin
    nmtHit = rxValid && rxCobId == conmt_pkg::NMT_COB_ID &&
             rxDlc == conmt_pkg::NMT_DLC &&
             (rxByte1 == conmt_pkg::NMT_BROADCAST ||
              rxByte1 == {1'b0, nodeFf}); // RL8 RL17
    cmdKnown = rxByte0 == conmt_pkg::CMD_START ||
               rxByte0 == conmt_pkg::CMD_STOP ||
               rxByte0 == conmt_pkg::CMD_PREOP ||
               rxByte0 == conmt_pkg::CMD_RST_NODE ||
               rxByte0 == conmt_pkg::CMD_RST_COMM; // RL17
    sdoHit = rxValid &&
             rxCobId == conmt_pkg::SDO_RX_BASE + {4'h0, nodeFf}; // RL15
  end

  // ***********************************************
  // State machine
  // ***********************************************
  always_comb begin
    nxtState = stateFf;
    unique case (stateFf)
      conmt_pkg::NmtInit: begin
        if (bootDoneFf) begin
          nxtState = conmt_pkg::NmtPreOp; // RL18 RL11
        end
      end
      conmt_pkg::NmtPreOp,
      conmt_pkg::NmtOper,
      conmt_pkg::NmtStopped: begin
        if (nmtHit && cmdKnown) begin // RL7 RL11
          unique case (rxByte0)
            conmt_pkg::CMD_START: nxtState = conmt_pkg::NmtOper; // RL9
            conmt_pkg::CMD_STOP:  nxtState = conmt_pkg::NmtStopped;
            conmt_pkg::CMD_PREOP: nxtState = conmt_pkg::NmtPreOp;
            default:              nxtState = conmt_pkg::NmtInit; // RL10
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stateFf <= conmt_pkg::NmtInit;
    end else begin
      stateFf <= nxtState;
    end
  end

  // Boot delay restarts on every entry into initializing
  always_ff @(posedge core_clk) begin
    if (srst || (stateFf != conmt_pkg::NmtInit)) begin
      bootCntFf  <= '0;
      bootDoneFf <= 1'b0;
    end else if (!bootDoneFf) begin
      if (bootCntFf >= 32'(BOOT_CYCLES - 1)) begin
        bootDoneFf <= 1'b1; // RL4
      end
      bootCntFf <= bootCntFf + 32'h1;
    end
  end

  // ***********************************************
  // Communication parameters
  // ***********************************************
  // Reset values come from storage once it has been loaded
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nodeFf  <= conmt_pkg::NODE_DEFAULT;
      rateFf  <= conmt_pkg::RATE_DEFAULT;
      nvStore <= 1'b0;
    end else begin
      nvStore <= 1'b0;
      if (nvLoaded && stateFf == conmt_pkg::NmtInit && !bootDoneFf) begin
        nodeFf <= nvNodeId; // RL14
        if (rateOk(nvBitRate)) begin
          rateFf <= nvBitRate;
        end
      end else if (cfgWrite && stateFf != conmt_pkg::NmtInit &&
                   stateFf != conmt_pkg::NmtStopped) begin
        nodeFf  <= cfgNodeId; // RL13
        if (rateOk(cfgBitRate)) begin
          rateFf <= cfgBitRate; // RL16
        end
        nvStore <= 1'b1; // RL14
      end
    end
  end

  // ***********************************************
  // Service gating and outputs
  // ***********************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bootTx     <= 1'b0;
      hbTx       <= 1'b0;
      tpdoTx     <= 2'h0;
      rpdoAccept <= 1'b0;
      sdoAccept  <= 1'b0;
      syncAccept <= 1'b0;
      sdoRespTx  <= 1'b0;
      appReset   <= 1'b0;
    end else begin
      bootTx <= stateFf == conmt_pkg::NmtInit &&
                nxtState == conmt_pkg::NmtPreOp; // RL4 RL7 RL18
      hbTx <= hbEnable && hbTick &&
              (stateFf == conmt_pkg::NmtPreOp ||
               stateFf == conmt_pkg::NmtOper); // RL5
      tpdoTx <= (stateFf == conmt_pkg::NmtOper) ?
                (tpdoEnable & tpdoTrigger) : 2'h0; // RL6 RL7 RL12
      rpdoAccept <= stateFf == conmt_pkg::NmtOper; // RL7
      sdoAccept  <= stateFf == conmt_pkg::NmtPreOp ||
                    stateFf == conmt_pkg::NmtOper; // RL7
      syncAccept <= syncRx && (stateFf == conmt_pkg::NmtPreOp ||
                               stateFf == conmt_pkg::NmtOper); // RL7
      sdoRespTx  <= sdoHit && (stateFf == conmt_pkg::NmtPreOp ||
                               stateFf == conmt_pkg::NmtOper); // RL12 RL15
      appReset   <= nmtHit &&
                    rxByte0 == conmt_pkg::CMD_RST_NODE &&
                    stateFf != conmt_pkg::NmtInit; // RL10
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nmtState <= 2'h0;
      sdoRxId  <= 11'h000;
      sdoTxId  <= 11'h000;
      nodeId   <= 7'h00;
      bitRate  <= 3'h0;
      odArea   <= 3'h0;
      odSub    <= 8'h00;
    end else begin
      nmtState <= 2'(stateFf);
      sdoRxId  <= conmt_pkg::SDO_RX_BASE + {4'h0, nodeFf}; // RL15
      sdoTxId  <= conmt_pkg::SDO_TX_BASE + {4'h0, nodeFf}; // RL15
      nodeId   <= nodeFf;
      bitRate  <= rateFf;
      odArea   <= 3'(areaComb); // RL1 RL3
      odSub    <= subComb; // RL2
    end
  end

  conmt_od_decode uDecode (
    .odIndex    (odIndex),
    .odSubIndex (odSubIndex),
    .odArea     (areaComb),
    .odSub      (subComb)
  );
endmodule
`default_nettype wire

// ===== conmt_assertions.sv
// Checker: timing relations at the state block's ports
`timescale 1ns/1ps
`default_nettype none
module conmt_assertions (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        rxValid,
  input wire logic [10:0] rxCobId,
  input wire logic [3:0]  rxDlc,
  input wire logic [7:0]  rxByte0,
  input wire logic [7:0]  rxByte1,
  input wire logic [1:0]  nmtState,
  input wire logic        hbTx,
  input wire logic [1:0]  tpdoTx,
  input wire logic        rpdoAccept,
  input wire logic        sdoAccept,
  input wire logic [10:0] sdoRxId,
  input wire logic [6:0]  nodeId,
  input wire logic [2:0]  bitRate,
  input wire logic        appReset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  logic forMe;
  logic hit;
  logic rstCmdFf;
  assign forMe = rxByte1 == 8'h00 || rxByte1 == {1'b0, nodeId};
  // Frames in init are refused, so only count them once booted
  // State port lags a cycle: a frame right after a reset meets init
  assign hit = rxValid && rxCobId == 11'h000 && rxDlc == 4'h2
               && nmtState != 2'h0 && forMe && !rstCmdFf;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rstCmdFf <= 1'b0;
    end else begin
      rstCmdFf <= hit && (rxByte0 == 8'h81 || rxByte0 == 8'h82);
    end
  end
  start_cmd_a: assert property (hit && rxByte0 == 8'h01
    |-> ##2 nmtState == 2'h2) else $error("start not taken");
  stop_cmd_a: assert property (hit && rxByte0 == 8'h02
    |-> ##2 nmtState == 2'h3) else $error("stop not taken");
  preop_cmd_a: assert property (hit && rxByte0 == 8'h80
    |-> ##2 nmtState == 2'h1) else $error("preop not taken");
  node_reset_a: assert property (hit && rxByte0 == 8'h81
    |-> ##[1:2] appReset) else $error("no app reset");
  comm_reset_a: assert property (hit && rxByte0 == 8'h82
    |=> !appReset [*2] ##0 nmtState == 2'h0) else $error("comm reset");
  foreign_ignore_a: assert property (rxValid && !forMe
    && nmtState != 2'h0 |=> ##1 $stable(nmtState)) else $error("foreign");
  pdo_gate_a: assert property (tpdoTx != 2'h0 || rpdoAccept
    |-> nmtState == 2'h2) else $error("pdo outside oper");
  sdo_gate_a: assert property (sdoAccept || hbTx
    |-> nmtState == 2'h1 || nmtState == 2'h2) else $error("sdo gate");
  sdo_id_a: assert property (nmtState != 2'h0 && $stable(nodeId)
    |-> sdoRxId == 11'h600 + {4'h0, nodeId}) else $error("sdo id");
  rate_code_a: assert property (bitRate != 3'h7)
    else $error("bad rate");
endmodule
bind conmt_state_ctrl conmt_assertions u_conmt_assertions (
  .core_clk(core_clk), .srst(srst), .rxValid(rxValid),
  .rxCobId(rxCobId), .rxDlc(rxDlc), .rxByte0(rxByte0),
  .rxByte1(rxByte1), .nmtState(nmtState), .hbTx(hbTx),
  .tpdoTx(tpdoTx), .rpdoAccept(rpdoAccept), .sdoAccept(sdoAccept),
  .sdoRxId(sdoRxId), .nodeId(nodeId), .bitRate(bitRate),
  .appReset(appReset));
`default_nettype wire

// ===== conmt_master_model.sv
// Network master model: places received frames on the block's port
`timescale 1ns/1ps
`default_nettype none
module conmt_master_model (
  input  wire logic  clk,
  output logic       rxValid,
  output logic [10:0] rxCobId,
  output logic [3:0] rxDlc,
  output logic [7:0] rxByte0,
  output logic [7:0] rxByte1
);
  initial begin
    rxValid = 1'b0;
    {rxCobId, rxDlc, rxByte0, rxByte1} = '1;
  end
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [7:0] cmd, input logic [7:0] adr);
    @(posedge clk);
    rxValid <= 1'b1;
    {rxCobId, rxDlc, rxByte0, rxByte1} <= {id, dlc, cmd, adr};
    @(posedge clk);
    rxValid <= 1'b0;
    // Stale fields are inverted so a late sample cannot match
    {rxCobId, rxDlc, rxByte0, rxByte1} <= ~{id, dlc, cmd, adr};
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the network-management state block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk, srst, rxValid, cfgWrite, hbEnable, hbTick, syncRx;
  logic [10:0] rxCobId, sdoRxId, sdoTxId;
  logic [3:0]  rxDlc;
  logic [7:0]  rxByte0, rxByte1, odSubIndex, odSub;
  logic [6:0]  cfgNodeId, nodeId, expNode, nvNodeId;
  logic [2:0]  cfgBitRate, bitRate, odArea, nvBitRate;
  logic [1:0]  tpdoEnable, tpdoTrigger, nmtState, tpdoTx;
  logic [15:0] odIndex;
  logic        bootTx, hbTx, rpdoAccept, sdoAccept, syncAccept, nvStore;
  logic        appReset, sdoRespTx, nvLoaded;
  int          n_fail = 0, check_count = 0, cycles = 0, expSt = 0;
  int unsigned seed = 38605, r;
  logic [15:0] odTab [9] = '{16'h0000, 16'h0001, 16'h00a0, 16'h0fff,
    16'h1fff, 16'h2000, 16'h5fff, 16'h6000, 16'ha000};
  logic [2:0]  areaTab [9] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4,
    3'h5, 3'h2};
  logic [7:0]  cmdTab [6] = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82, 8'h55};
  conmt_state_ctrl #(.BOOT_CYCLES(20)) u_conmt_state_ctrl (
    .core_clk(core_clk), .srst(srst), .rxValid(rxValid),
    .rxCobId(rxCobId), .rxDlc(rxDlc), .rxByte0(rxByte0),
    .rxByte1(rxByte1), .cfgWrite(cfgWrite), .cfgNodeId(cfgNodeId),
    .cfgBitRate(cfgBitRate), .nvLoaded(nvLoaded), .nvNodeId(nvNodeId),
    .nvBitRate(nvBitRate), .hbEnable(hbEnable), .hbTick(hbTick),
    .tpdoEnable(tpdoEnable), .tpdoTrigger(tpdoTrigger), .syncRx(syncRx),
    .odIndex(odIndex), .odSubIndex(odSubIndex), .nmtState(nmtState),
    .bootTx(bootTx), .hbTx(hbTx), .tpdoTx(tpdoTx),
    .rpdoAccept(rpdoAccept), .sdoAccept(sdoAccept),
    .syncAccept(syncAccept), .sdoRespTx(sdoRespTx), .sdoRxId(sdoRxId),
    .sdoTxId(sdoTxId), .nodeId(nodeId), .bitRate(bitRate),
    .nvStore(nvStore), .appReset(appReset), .odArea(odArea), .odSub(odSub));
  conmt_master_model master (.clk(core_clk), .rxValid(rxValid),
    .rxCobId(rxCobId), .rxDlc(rxDlc), .rxByte0(rxByte0), .rxByte1(rxByte1));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic waitBoot();
    for (int i = 0; i < 60 && bootTx !== 1'b1; i++) tick(1);
    chk("bootTx", bootTx, 16'h1);
    tick(1);
    chk("nmtState", nmtState, 16'h1);
    expSt = 1;
  endtask
  task automatic gates();
    logic h, s, hbOn;
    logic [1:0] p, en;
    {h, s, p} = '0;
    {hbOn, en} = 3'(rnd());
    @(posedge core_clk);
    hbEnable <= hbOn;
    tpdoEnable <= en;
    @(posedge core_clk);
    {hbTick, syncRx, tpdoTrigger} <= 4'hf;
    @(posedge core_clk);
    {hbTick, syncRx, tpdoTrigger} <= 4'h0;
    repeat (3) begin
      #1;
      {h, s, p} = {h, s, p} | {hbTx, syncAccept, tpdoTx};
      @(posedge core_clk);
    end
    #1;
    chk("hbTx", h, hbOn && (expSt == 1 || expSt == 2));
    chk("syncAccept", s, expSt == 1 || expSt == 2);
    chk("tpdoTx", p, expSt == 2 ? en : 2'h0);
    chk("rpdoAccept", rpdoAccept, expSt == 2);
    chk("sdoAccept", sdoAccept, expSt == 1 || expSt == 2);
  endtask
  task automatic nmt(input logic [10:0] id, input logic [3:0] dlc,
                     input logic [7:0] cmd, input logic [7:0] adr);
    logic take;
    take = id == 11'h000 && dlc == 4'h2 && expSt != 0 &&
           (adr == 8'h00 || adr == {1'b0, expNode});
    if (take) begin
      case (cmd)
        8'h01: expSt = 2;
        8'h02: expSt = 3;
        8'h80: expSt = 1;
        8'h81, 8'h82: expSt = 0;
        default: ;
      endcase
    end
    master.send(id, dlc, cmd, adr);
    #1;
    chk("appReset", appReset, take && cmd == 8'h81);
    tick(2);
    chk("nmtState", nmtState, 16'(expSt));
    if (expSt == 0) waitBoot();
    gates();
  endtask
  task automatic cfg(input logic [6:0] n, input logic [2:0] rate);
    @(posedge core_clk);
    {cfgWrite, cfgNodeId, cfgBitRate} <= {1'b1, n, rate};
    @(posedge core_clk);
    cfgWrite <= 1'b0;
    #1;
    chk("nvStore", nvStore, expSt == 1 || expSt == 2);
    tick(2);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {srst, cfgWrite, hbEnable, hbTick, syncRx} = 5'h10;
    {cfgNodeId, cfgBitRate, tpdoEnable, tpdoTrigger} = '0;
    {odIndex, odSubIndex} = '0;
    {nvLoaded, nvNodeId, nvBitRate} = '0;
    expNode = 7'h01;
    tick(15);
    chk("nmtState", nmtState, 16'h0);
    @(posedge core_clk);
    srst <= 1'b0;
    master.send(11'h000, 4'h2, 8'h01, 8'h00);
    waitBoot();
    chk("nodeId", nodeId, 16'h1);
    chk("bitRate", bitRate, 16'h3);
    $display("test boot done");
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      odIndex <= odTab[i];
      odSubIndex <= 8'(rnd());
      tick(3);
      chk("odArea", odArea, 16'(areaTab[i]));
      chk("odSub", odSub, 16'(odSubIndex));
    end
    $display("test dictionary done");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      nmt(r[4:2] == 3'h0 ? 11'h700 : 11'h000,
          r[7:5] == 3'h0 ? 4'h8 : 4'h2, cmdTab[r[10:8] % 6],
          r[12:11] == 2'h0 ? 8'h33 : r[12] ? {1'b0, expNode} : 8'h00);
    end
    $display("test commands done");
    nmt(11'h000, 4'h2, 8'h80, 8'h00);
    cfg(7'h05, 3'h2);
    expNode = 7'h05;
    chk("nodeId", nodeId, 16'h5);
    chk("bitRate", bitRate, 16'h2);
    chk("sdoRxId", sdoRxId, 16'h605);
    chk("sdoTxId", sdoTxId, 16'h585);
    cfg(7'h05, 3'h7);
    chk("bitRate", bitRate, 16'h2);
    nmt(11'h000, 4'h2, 8'h01, 8'h05);
    nmt(11'h000, 4'h2, 8'h02, 8'h01);
    master.send(11'h605, 4'h8, 8'h40, 8'h00);
    #1;
    chk("sdoRespTx", sdoRespTx, 16'h1);
    nmt(11'h000, 4'h2, 8'h02, 8'h05);
    master.send(11'h605, 4'h8, 8'h40, 8'h00);
    #1;
    chk("sdoRespTx", sdoRespTx, 16'h0);
    cfg(7'h09, 3'h1);
    chk("nodeId", nodeId, 16'h5);
    chk("bitRate", bitRate, 16'h2);
    $display("test configuration done");
    @(posedge core_clk);
    {nvLoaded, nvNodeId, nvBitRate} <= {1'b1, 7'h07, 3'h5};
    nmt(11'h000, 4'h2, 8'h82, 8'h00);
    chk("nodeId", nodeId, 16'h7);
    chk("bitRate", bitRate, 16'h5);
    $display("test storage done");
    test_done();
  end
endmodule
`default_nettype wire
